/* File: design/vmer_pkg.sv */
// Package of the voltage monitor event register file.
// Assumes an 8-bit register port with one-cycle strobes and read data one cycle later.
package vmer_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] OFF_STS_LO = 4'h0;
	localparam logic [3:0] OFF_STS_HI = 4'h1;
	localparam logic [3:0] OFF_MGMT_LO = 4'h2;
	localparam logic [3:0] OFF_MGMT_HI = 4'h3;
	localparam logic [3:0] OFF_IRQ_LO = 4'h4;
	localparam logic [3:0] OFF_IRQ_HI = 4'h5;
	localparam logic [3:0] OFF_VCODE = 4'h6;
	localparam logic [3:0] OFF_CRATE = 4'h7;
	localparam logic [3:0] OFF_CFG = 4'h8;
	localparam logic [3:0] OFF_BANK = 4'h9;
	localparam logic [3:0] OFF_CH_CFG = 4'hA;
	localparam logic [3:0] OFF_CH_READ = 4'hB;
	localparam logic [3:0] OFF_CH_HIGH = 4'hC;
	localparam logic [3:0] OFF_CH_LOW = 4'hD;
	localparam logic [3:0] OFF_CH_OT = 4'hE;
	localparam logic [7:0] STS_LO_MASK = 8'hFF;
	localparam logic [7:0] STS_HI_MASK = 8'h3F;
	localparam logic [7:0] VCODE_SEL_MASK = 8'hC0;
	localparam logic [7:0] RESET_ZERO = 8'h00;
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam int NUM_BANKS = 13;
	localparam int BANK_REGS = 5;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} vmer_req_type;
endpackage

/* File: design/vmer_regs.sv */
// Host-visible register file of the voltage monitor: event status, enables, banks.
// Assumes single-clock host port; channel events arrive as one-cycle pulses on clk.
//
// Contract
// - Common registers occupy offsets 00h to 09h in the documented order.
// - Offsets 0Ah to 0Eh reach the selected bank's five channel registers, 0Fh is reserved.
// - Status low holds standby supply flag in bit 7 and analog input flags in bits 6-0.
// - Status high bits 5-3 flag temperature channels three to one, bits 7-6 reserved.
// - Status high bits 2-0 flag analog supply, battery and core supply channels.
// - All status flags are zero after reset and host writes cannot set them.
// - Management enable low has one reset-zero enable bit per status low flag.
// - Each interrupt output is active while a status bit and its own enable are both set.
// - Status bits stay set until software writes 1 to clear them.
// - Thirteen banks of five registers are chosen by the bank select register.
// - Bank select resets to bank 0.
module vmer_regs #(
	parameter int NUM_BANKS = vmer_pkg::NUM_BANKS
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Host register port.
	input wire vmer_pkg::vmer_req_type req,
	output logic [7:0] rdata,
	// Channel events and readings.
	input wire logic [7:0] event_low,
	input wire logic [7:0] event_high,
	input wire logic [7:0] reading_in [NUM_BANKS],
	input wire logic [4:0] cpu_voltage_code_in,
	input wire logic [7:0] chan_status_in [NUM_BANKS],
	// Interrupts and control.
	output logic mgmt_interrupt,
	output logic host_irq,
	output logic [7:0] conversion_rate_out,
	output logic [7:0] monitor_config_out
);
	////////////////////////////////////////////////////////////////
	logic [7:0] event_status_low;
	logic [7:0] event_status_high;
	logic [7:0] mgmt_irq_enable_low;
	logic [7:0] mgmt_irq_enable_high;
	logic [7:0] host_irq_enable_low;
	logic [7:0] host_irq_enable_high;
	logic [7:0] code_select;
	logic [7:0] conversion_rate;
	logic [7:0] monitor_config;
	logic [3:0] bank_select;
	logic [7:0] ch_cfg [NUM_BANKS];
	logic [7:0] ch_high [NUM_BANKS];
	logic [7:0] ch_low [NUM_BANKS];
	logic [7:0] ch_ot [NUM_BANKS];
	logic [4:0] code_s1;
	logic [4:0] code_s2;
	////////////////////////////////////////////////////////////////
	// Request fields.
	wire wr = req.wr;
	wire rd = req.rd;
	wire [3:0] a = req.addr;
	wire [7:0] wd = req.wdata;

	////////////////////////////////////////////////////////////////

	wire hit_sts_low = a == vmer_pkg::OFF_STS_LO;
	wire hit_sts_high = a == vmer_pkg::OFF_STS_HI;
	wire hit_mgmt_low = a == vmer_pkg::OFF_MGMT_LO;
	wire hit_mgmt_high = a == vmer_pkg::OFF_MGMT_HI;
	wire hit_irq_low = a == vmer_pkg::OFF_IRQ_LO;
	wire hit_irq_high = a == vmer_pkg::OFF_IRQ_HI;
	wire hit_vcode = a == vmer_pkg::OFF_VCODE;
	wire hit_crate = a == vmer_pkg::OFF_CRATE;
	wire hit_cfg = a == vmer_pkg::OFF_CFG;
	wire hit_bank = a == vmer_pkg::OFF_BANK;

	wire hit_ch_cfg = a == vmer_pkg::OFF_CH_CFG;
	wire hit_ch_read = a == vmer_pkg::OFF_CH_READ;
	wire hit_ch_high = a == vmer_pkg::OFF_CH_HIGH;
	wire hit_ch_low = a == vmer_pkg::OFF_CH_LOW;
	wire hit_ch_ot = a == vmer_pkg::OFF_CH_OT;

	wire bank_ok = bank_select < 4'(NUM_BANKS);
	wire [3:0] bank_idx = bank_ok ? bank_select : vmer_pkg::BANK_RESET;

	////////////////////////////////////////////////////////////////

	// Write strobes of the common registers and the selected bank's channel registers.
	wire we_sts_low = wr && hit_sts_low;
	wire we_sts_high = wr && hit_sts_high;
	wire we_mgmt_low = wr && hit_mgmt_low;
	wire we_mgmt_high = wr && hit_mgmt_high;
	wire we_irq_low = wr && hit_irq_low;
	wire we_irq_high = wr && hit_irq_high;
	wire we_vcode = wr && hit_vcode;
	wire we_crate = wr && hit_crate;
	wire we_cfg = wr && hit_cfg;
	wire we_bank = wr && hit_bank;

	wire we_ch_cfg = wr && hit_ch_cfg && bank_ok;
	wire we_ch_high = wr && hit_ch_high && bank_ok;
	wire we_ch_low = wr && hit_ch_low && bank_ok;
	wire we_ch_ot = wr && hit_ch_ot && bank_ok;

	////////////////////////////////////////////////////////////////

	wire [7:0] next_mgmt_low = we_mgmt_low ? wd : mgmt_irq_enable_low;
	wire [7:0] next_mgmt_high = we_mgmt_high ? (wd & vmer_pkg::STS_HI_MASK) : mgmt_irq_enable_high;
	wire [7:0] next_irq_low = we_irq_low ? wd : host_irq_enable_low;
	wire [7:0] next_irq_high = we_irq_high ? (wd & vmer_pkg::STS_HI_MASK) : host_irq_enable_high;
	wire [7:0] next_code_select = we_vcode ? (wd & vmer_pkg::VCODE_SEL_MASK) : code_select;
	wire [7:0] next_crate = we_crate ? wd : conversion_rate;
	wire [7:0] next_cfg = we_cfg ? wd : monitor_config;
	wire [3:0] next_bank = we_bank ? wd[3:0] : bank_select;

	////////////////////////////////////////////////////////////////

	wire [7:0] clr_low = we_sts_low ? wd : 8'h00;
	wire [7:0] clr_high = we_sts_high ? wd : 8'h00;

	wire [7:0] set_low = event_low & vmer_pkg::STS_LO_MASK;

	wire [7:0] set_high = event_high & vmer_pkg::STS_HI_MASK;

	wire [7:0] next_sts_low = (event_status_low & ~clr_low) | set_low;
	wire [7:0] next_sts_high = (event_status_high & ~clr_high) | set_high;

	////////////////////////////////////////////////////////////////

	wire [7:0] mgmt_pend_low = event_status_low & mgmt_irq_enable_low;
	wire [7:0] mgmt_pend_high = event_status_high & mgmt_irq_enable_high;
	wire [7:0] host_pend_low = event_status_low & host_irq_enable_low;
	wire [7:0] host_pend_high = event_status_high & host_irq_enable_high;

	wire mgmt_any_low = |mgmt_pend_low;
	wire mgmt_any_high = |mgmt_pend_high;
	wire host_any_low = |host_pend_low;
	wire host_any_high = |host_pend_high;

	assign mgmt_interrupt = mgmt_any_low | mgmt_any_high;
	assign host_irq = host_any_low | host_any_high;
	assign conversion_rate_out = conversion_rate;
	assign monitor_config_out = monitor_config;

	////////////////////////////////////////////////////////////////

	always_ff @(posedge clk) begin
		if (srst) begin
			event_status_low <= vmer_pkg::RESET_ZERO;
		end else begin
			event_status_low <= next_sts_low;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			event_status_high <= vmer_pkg::RESET_ZERO;
		end else begin
			event_status_high <= next_sts_high;
		end
	end

	// Pin synchroniser stage one.
	always_ff @(posedge clk) begin
		if (srst) begin
			code_s1 <= 5'h00;
		end else begin
			code_s1 <= cpu_voltage_code_in;
		end
	end

	// Pin synchroniser stage two.
	always_ff @(posedge clk) begin
		if (srst) begin
			code_s2 <= 5'h00;
		end else begin
			code_s2 <= code_s1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mgmt_irq_enable_low <= vmer_pkg::RESET_ZERO;
		end else begin
			mgmt_irq_enable_low <= next_mgmt_low;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mgmt_irq_enable_high <= vmer_pkg::RESET_ZERO;
		end else begin
			mgmt_irq_enable_high <= next_mgmt_high;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			host_irq_enable_low <= vmer_pkg::RESET_ZERO;
		end else begin
			host_irq_enable_low <= next_irq_low;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			host_irq_enable_high <= vmer_pkg::RESET_ZERO;
		end else begin
			host_irq_enable_high <= next_irq_high;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			code_select <= vmer_pkg::RESET_ZERO;
		end else begin
			code_select <= next_code_select;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			conversion_rate <= vmer_pkg::RESET_ZERO;
		end else begin
			conversion_rate <= next_crate;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			monitor_config <= vmer_pkg::RESET_ZERO;
		end else begin
			monitor_config <= next_cfg;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			bank_select <= vmer_pkg::BANK_RESET;
		end else begin
			bank_select <= next_bank;
		end
	end

	////////////////////////////////////////////////////////////////

	for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
		wire sel = bank_select == 4'(i);
		wire wr_cfg = we_ch_cfg && sel;
		wire wr_high = we_ch_high && sel;
		wire wr_low = we_ch_low && sel;
		wire wr_ot = we_ch_ot && sel;

		always_ff @(posedge clk) begin
			if (srst) begin
				ch_cfg[i] <= vmer_pkg::RESET_ZERO;
			end else if (wr_cfg) begin
				ch_cfg[i] <= wd;
			end
		end

		always_ff @(posedge clk) begin
			if (srst) begin
				ch_high[i] <= vmer_pkg::RESET_ZERO;
			end else if (wr_high) begin
				ch_high[i] <= wd;
			end
		end

		always_ff @(posedge clk) begin
			if (srst) begin
				ch_low[i] <= vmer_pkg::RESET_ZERO;
			end else if (wr_low) begin
				ch_low[i] <= wd;
			end
		end

		always_ff @(posedge clk) begin
			if (srst) begin
				ch_ot[i] <= vmer_pkg::RESET_ZERO;
			end else if (wr_ot) begin
				ch_ot[i] <= wd;
			end
		end
	end

	////////////////////////////////////////////////////////////////

	wire [7:0] bank_cfg_stored = ch_cfg[bank_idx];
	wire [7:0] bank_cfg_status = chan_status_in[bank_idx];
	wire [7:0] bank_cfg_val = bank_cfg_stored | bank_cfg_status;
	wire [7:0] bank_read_val = reading_in[bank_idx];
	wire [7:0] bank_high_val = ch_high[bank_idx];
	wire [7:0] bank_low_val = ch_low[bank_idx];
	wire [7:0] bank_ot_val = ch_ot[bank_idx];
	wire [7:0] code_value = {3'h0, code_s2};
	wire [7:0] code_read = code_select | code_value;

	wire [7:0] rd_sts_low = hit_sts_low ? event_status_low : 8'h00;
	wire [7:0] rd_sts_high = hit_sts_high ? event_status_high : 8'h00;
	wire [7:0] rd_mgmt_low = hit_mgmt_low ? mgmt_irq_enable_low : 8'h00;
	wire [7:0] rd_mgmt_high = hit_mgmt_high ? mgmt_irq_enable_high : 8'h00;
	wire [7:0] rd_irq_low = hit_irq_low ? host_irq_enable_low : 8'h00;
	wire [7:0] rd_irq_high = hit_irq_high ? host_irq_enable_high : 8'h00;
	wire [7:0] rd_vcode = hit_vcode ? code_read : 8'h00;
	wire [7:0] rd_crate = hit_crate ? conversion_rate : 8'h00;
	wire [7:0] rd_cfg = hit_cfg ? monitor_config : 8'h00;
	wire [7:0] rd_bank = hit_bank ? {4'h0, bank_select} : 8'h00;

	wire [7:0] rd_ch_cfg = (hit_ch_cfg && bank_ok) ? bank_cfg_val : 8'h00;
	wire [7:0] rd_ch_read = (hit_ch_read && bank_ok) ? bank_read_val : 8'h00;
	wire [7:0] rd_ch_high = (hit_ch_high && bank_ok) ? bank_high_val : 8'h00;
	wire [7:0] rd_ch_low = (hit_ch_low && bank_ok) ? bank_low_val : 8'h00;
	wire [7:0] rd_ch_ot = (hit_ch_ot && bank_ok) ? bank_ot_val : 8'h00;

	// Read data select.
	wire [7:0] common_rdata = rd_sts_low
		| rd_sts_high
		| rd_mgmt_low
		| rd_mgmt_high
		| rd_irq_low
		| rd_irq_high
		| rd_vcode
		| rd_crate
		| rd_cfg
		| rd_bank;
	wire [7:0] bank_rdata = rd_ch_cfg
		| rd_ch_read
		| rd_ch_high
		| rd_ch_low
		| rd_ch_ot;
	wire [7:0] next_rdata = common_rdata | bank_rdata;

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd ? next_rdata : 8'h00;
		end
	end
endmodule

/* File: tb/vmer_regs_asserts.sv */
// Checker of the voltage monitor event register file.
// Assumes the host port, events and interrupts of vmer_regs on one clock.
module vmer_chk (
	// Clock, reset and host port.
	input wire logic clk,
	input wire logic srst,
	input wire vmer_pkg::vmer_req_type req,
	input wire logic [7:0] rdata,
	// Events and interrupts.
	input wire logic [7:0] event_low,
	input wire logic [7:0] event_high,
	input wire logic mgmt_interrupt,
	input wire logic host_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	rdata_idle_a: assert property (!$past(req.rd) |-> rdata == 8'h00) else $error("rdata idle");
	hi_rsvd_a: assert property ($past(req.rd) && $past(req.addr) == 4'h1 |-> rdata[7:6] == 2'h0) else $error("rsvd");
	slot_zero_a: assert property ($past(req.rd) && $past(req.addr) == 4'hF |-> rdata == 8'h00) else $error("slot");
	low_set_a: assert property (event_low != 8'h00 ##1 !req.wr ##1 req.rd && req.addr == 4'h0
		|=> (rdata & $past(event_low, 3)) == $past(event_low, 3)) else $error("low set");
	high_set_a: assert property (event_high != 8'h00 ##1 !req.wr ##1 req.rd && req.addr == 4'h1
		|=> (rdata[5:0] & $past(event_high[5:0], 3)) == $past(event_high[5:0], 3)) else $error("high set");
	mgmt_hold_a: assert property (mgmt_interrupt && !req.wr |=> mgmt_interrupt) else $error("mgmt drop");
	host_hold_a: assert property (host_irq && !req.wr |=> host_irq) else $error("host drop");
	mgmt_cause_a: assert property ($rose(mgmt_interrupt) |-> $past(req.wr) || $past(event_low | event_high) != 8'h00)
		else $error("mgmt cause");
	host_cause_a: assert property ($rose(host_irq) |-> $past(req.wr) || $past(event_low | event_high) != 8'h00)
		else $error("host cause");
	cover property (req.rd && req.addr == 4'h0 ##1 rdata != 8'h00);
	cover property ($rose(mgmt_interrupt));
	cover property ($rose(host_irq));
endmodule
bind vmer_regs vmer_chk chk_u (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .event_low(event_low),
	.event_high(event_high), .mgmt_interrupt(mgmt_interrupt), .host_irq(host_irq));

/* File: tb/vmer_regs_bench.sv */
// Self-checking bench of the voltage monitor event register file.
// Assumes vmer_regs with thirteen banks on a 100 MHz clock.
module vmer_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	vmer_pkg::vmer_req_type req = '0;
	logic [7:0] rdata, event_low = 8'h00, event_high = 8'h00, lf = 8'h16, v, e, m;
	logic [7:0] reading_in [13];
	logic [7:0] chan_status_in [13] = '{default: 8'h00};
	logic [7:0] lim [13];
	logic mgmt_interrupt, host_irq;
	logic [7:0] rate_seen, cfg_seen;
	logic [4:0] code_pins = 5'h00;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	vmer_regs dut_u (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .event_low(event_low),
		.event_high(event_high), .reading_in(reading_in), .cpu_voltage_code_in(code_pins),
		.chan_status_in(chan_status_in), .mgmt_interrupt(mgmt_interrupt), .host_irq(host_irq),
		.conversion_rate_out(rate_seen), .monitor_config_out(cfg_seen));
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] nxt();
		lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		return lf;
	endfunction
	function automatic logic [7:0] w1c(input logic [7:0] s, input logic [7:0] c);
		return s & ~c;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic summarize();
		if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		for (int i = 0; i < 13; i++) reading_in[i] = nxt();
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		for (int a = 0; a < 16; a++) rd(a[3:0], (a == 11) ? reading_in[0] : 8'h00);
		repeat (20) begin
			v = nxt();
			e = nxt();
			m = nxt();
			@(posedge clk);
			event_low <= v;
			event_high <= m;
			@(posedge clk);
			event_low <= 8'h00;
			event_high <= 8'h00;
			rd(4'h0, v);
			rd(4'h1, m & 8'h3F);
			wr(4'h2, e);
			wr(4'h3, e);
			wr(4'h4, e);
			wr(4'h5, m);
			#1 chk({7'h00, mgmt_interrupt}, {7'h00, |(v & e) | |(m & e & 8'h3F)});
			chk({7'h00, host_irq}, {7'h00, |(v & e) | |(m & 8'h3F)});
			rd(4'h2, e);
			rd(4'h3, e & 8'h3F);
			rd(4'h0, v);
			wr(4'h0, e);
			wr(4'h1, 8'hFF);
			#1 chk({6'h00, mgmt_interrupt, host_irq}, 8'h00);
			rd(4'h0, w1c(v, e));
			rd(4'h1, 8'h00);
			wr(4'h0, 8'hFF);
		end
		for (int b = 0; b < 13; b++) begin
			lim[b] = nxt();
			wr(4'h9, b[7:0]);
			wr(4'hC, lim[b]);
			rd(4'hB, reading_in[b]);
		end
		wr(4'h9, 8'h0D);
		wr(4'hC, 8'hFF);
		for (int b = 0; b < 13; b++) begin
			wr(4'h9, b[7:0]);
			rd(4'hC, lim[b]);
			rd(4'hF, 8'h00);
		end
		v = nxt();
		e = nxt();
		@(posedge clk);
		code_pins <= v[4:0];
		chan_status_in[3] <= e;
		wr(4'h6, 8'hFF);
		wr(4'h7, v);
		wr(4'h8, e);
		wr(4'h9, 8'h03);
		wr(4'hA, 8'h5A);
		rd(4'h6, {3'h6, v[4:0]});
		rd(4'hA, e | 8'h5A);
		rd(4'h9, 8'h03);
		#1 chk(rate_seen, v);
		chk(cfg_seen, e);
		summarize();
	end
endmodule
